// *** core/latch_status_cell.sv ***
`timescale 1ns/100ps
`default_nettype none
module latch_status_cell #(
	parameter int W = 1,
	parameter phy_mgmt_pkg::latch_kind_e KIND = phy_mgmt_pkg::LATCH_HIGH,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] mon,
	input wire logic rd_pulse,
	input wire logic reinit,
	output logic [W-1:0] value
);
	logic [W-1:0] value_q;

	// whole group compared as one unsigned number, msb first
	function automatic logic [W-1:0] next_value(input logic [W-1:0] held,
			input logic [W-1:0] live);
		case (KIND)
			phy_mgmt_pkg::LATCH_HIGH: next_value = held | live;
			phy_mgmt_pkg::LATCH_LOW: next_value = held & live;
			default: next_value = (live > held) ? live : held;
		endcase
	endfunction

	// a read reloads the live state, so an event in the read cycle is kept
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			value_q <= INIT;
		end else if (reinit) begin
			// set wins: an event in the reinit cycle still lands on top of the default
			value_q <= next_value(INIT, mon);
		end else if (rd_pulse) begin
			value_q <= mon;
		end else begin
			value_q <= next_value(value_q, mon);
		end
	end

	assign value = value_q;
endmodule
`default_nettype wire

// *** core/phy_mgmt_ctrl.sv ***
// Behaviour
// - active-high event bit holds one until reset or read, then reloads live signal.
// - second back-to-back read of active-high event bit returns live state.
// - active-low event bit holds zero until reset or read, then reloads live signal.
// - second back-to-back read of active-low event bit returns live state.
// - maximum group captures only strictly larger values, msb first.
// - maximum group holds until reset or read, then loads live state.
// - self-clearing triggers default zero, start on one, clear when done.
// - writing one to control bit 15 starts software reset of all registers.
// - during software reset bit 15 reads one and writes are ignored.
// - loopback disables line transmitter, receiver, collision; loops mac transmit to receive.
// - in loopback receive valid follows transmit enable within 512 bit times.
// - collision test keeps collision detection on during loopback.
// - hardware configuration ignores rate bit and uses rate select pin.
// - software configuration uses rate bit unless auto-negotiation supplies rate.
// - detailed status bit 15 reports active link rate.
// - control word fields at bits 15 down to 7 as laid out.
// - rate and negotiation enable default one; isolate default follows strapped address.
// - control bits 6 to 0 read zero; writer must send defaults.
// - entering low power reinitialises only the event latch bits.
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_ctrl #(
	parameter int SW_RESET_CYCLES = phy_mgmt_pkg::SW_RESET_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire phy_mgmt_pkg::mgmt_req_s mgmt_req,
	output phy_mgmt_pkg::mgmt_rsp_s mgmt_rsp,
	input wire logic config_source_pin,
	input wire logic rate_select_pin,
	input wire logic [phy_mgmt_pkg::STRAP_W-1:0] phy_addr_strap,
	input wire logic link_event,
	input wire logic link_fault_n,
	input wire logic [phy_mgmt_pkg::MAX_W-1:0] mon_state,
	input wire logic neg_rate_100,
	input wire logic an_restart_done,
	input wire phy_mgmt_pkg::mii_beat_s mac_tx,
	input wire phy_mgmt_pkg::mii_beat_s line_rx,
	output phy_mgmt_pkg::mii_beat_s mac_rx,
	output phy_mgmt_pkg::mii_beat_s line_tx,
	output logic tp_tx_enable,
	output logic tp_rx_enable,
	output logic coll_detect_enable,
	output logic rate_100,
	output logic an_enable,
	output logic an_restart,
	output logic low_power,
	output logic isolate,
	output logic duplex_full,
	output logic state_reset,
	output logic mgmt_busy
);
	localparam int CNT_W = $clog2(SW_RESET_CYCLES + phy_mgmt_pkg::BOOT_CYCLES + 1);
	localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(phy_mgmt_pkg::BOOT_CYCLES - 1);
	localparam logic [CNT_W-1:0] SWRST_LAST = CNT_W'(SW_RESET_CYCLES - 1);

	typedef enum {ST_BOOT, ST_RUN, ST_SWRST} ctl_state_e;

	ctl_state_e state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [phy_mgmt_pkg::DATA_W-1:0] ctl_q;
	logic [phy_mgmt_pkg::STRAP_W-1:0] strap_q;
	logic cfg_s1_q, cfg_s2_q, rsel_s1_q, rsel_s2_q;
	logic [phy_mgmt_pkg::STRAP_W-1:0] strap_s1_q, strap_s2_q;
	logic rate_100_q, tp_tx_q, tp_rx_q, coll_en_q;
	phy_mgmt_pkg::mgmt_rsp_s rsp_q;
	phy_mgmt_pkg::mii_beat_s mac_rx_q, line_tx_q;
	logic lh_q, ll_q;
	logic [phy_mgmt_pkg::MAX_W-1:0] max_q;
	logic [phy_mgmt_pkg::DATA_W-1:0] new_ctl;
	logic ctl_write, det_read, sw_start, lp_enter, latch_reinit;

	function automatic logic [phy_mgmt_pkg::DATA_W-1:0] ctl_image(
			input logic [phy_mgmt_pkg::STRAP_W-1:0] strap);
		logic [phy_mgmt_pkg::DATA_W-1:0] img;
		img = phy_mgmt_pkg::CTL_DEFAULT;
		img[phy_mgmt_pkg::CTL_ISOLATE] = (strap == phy_mgmt_pkg::STRAP_ISOLATE_ADDR);
		ctl_image = img;
	endfunction

	function automatic logic addr_hit(input phy_mgmt_pkg::mgmt_req_s req, input logic wr,
			input logic [phy_mgmt_pkg::ADDR_W-1:0] reg_addr);
		addr_hit = req.valid && (req.write == wr) && (req.addr == reg_addr);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_s1_q <= 1'b0;
			cfg_s2_q <= 1'b0;
			rsel_s1_q <= 1'b0;
			rsel_s2_q <= 1'b0;
			strap_s1_q <= '0;
			strap_s2_q <= '0;
		end else begin
			cfg_s1_q <= config_source_pin;
			cfg_s2_q <= cfg_s1_q;
			rsel_s1_q <= rate_select_pin;
			rsel_s2_q <= rsel_s1_q;
			strap_s1_q <= phy_addr_strap;
			strap_s2_q <= strap_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// access decode; writes only land while running

	assign ctl_write = (state_q == ST_RUN) && addr_hit(mgmt_req, 1'b1, phy_mgmt_pkg::REG_CONTROL);
	assign det_read = (state_q == ST_RUN) && addr_hit(mgmt_req, 1'b0, phy_mgmt_pkg::REG_DETAIL);
	assign new_ctl = mgmt_req.wdata & phy_mgmt_pkg::CTL_LIVE_MASK;
	assign sw_start = ctl_write && new_ctl[phy_mgmt_pkg::CTL_RESET];
	assign lp_enter = ctl_write && !sw_start && new_ctl[phy_mgmt_pkg::CTL_LOW_POWER]
		&& !ctl_q[phy_mgmt_pkg::CTL_LOW_POWER];
	assign latch_reinit = lp_enter || (state_q == ST_SWRST);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer: strap capture after release, then run; software reset on request

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_BOOT;
			cnt_q <= '0;
			strap_q <= '0;
		end else begin
			case (state_q)
				ST_BOOT: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == BOOT_LAST) begin
						// strap is read after it has passed the synchroniser
						strap_q <= strap_s2_q;
						cnt_q <= '0;
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (sw_start) begin
						cnt_q <= '0;
						state_q <= ST_SWRST;
					end
				end
				ST_SWRST: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == SWRST_LAST) begin
						cnt_q <= '0;
						state_q <= ST_RUN;
					end
				end
				default: begin
					state_q <= ST_BOOT;
					cnt_q <= '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_q <= phy_mgmt_pkg::CTL_DEFAULT;
		end else if (state_q == ST_BOOT) begin
			if (cnt_q == BOOT_LAST) begin
				ctl_q <= ctl_image(strap_s2_q);
			end
		end else if (state_q == ST_SWRST) begin
			ctl_q <= ctl_image(strap_q);
			// bit 15 stays up through the very last reset cycle
			ctl_q[phy_mgmt_pkg::CTL_RESET] <= (cnt_q != SWRST_LAST);
		end else if (sw_start) begin
			ctl_q <= ctl_image(strap_q);
			ctl_q[phy_mgmt_pkg::CTL_RESET] <= 1'b1;
		end else if (ctl_write) begin
			ctl_q <= new_ctl;
			// restart only arms with negotiation on; a pending request survives a rewrite
			ctl_q[phy_mgmt_pkg::CTL_AN_RESTART] <= new_ctl[phy_mgmt_pkg::CTL_AN_EN]
				&& (new_ctl[phy_mgmt_pkg::CTL_AN_RESTART]
				|| (ctl_q[phy_mgmt_pkg::CTL_AN_RESTART] && !an_restart_done));
		end else if (an_restart_done) begin
			ctl_q[phy_mgmt_pkg::CTL_AN_RESTART] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// latching status bits

	latch_status_cell #(
		.W(1),
		.KIND(phy_mgmt_pkg::LATCH_HIGH),
		.INIT(phy_mgmt_pkg::LATCH_HIGH_DEFAULT)
	) u_lh (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.mon(link_event),
		.rd_pulse(det_read),
		.reinit(latch_reinit),
		.value(lh_q)
	);

	latch_status_cell #(
		.W(1),
		.KIND(phy_mgmt_pkg::LATCH_LOW),
		.INIT(phy_mgmt_pkg::LATCH_LOW_DEFAULT)
	) u_ll (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.mon(link_fault_n),
		.rd_pulse(det_read),
		.reinit(latch_reinit),
		.value(ll_q)
	);

	// the maximum group is not an event latch, so low power leaves it alone
	latch_status_cell #(
		.W(phy_mgmt_pkg::MAX_W),
		.KIND(phy_mgmt_pkg::LATCH_MAX),
		.INIT(phy_mgmt_pkg::MAX_DEFAULT)
	) u_max (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.mon(mon_state),
		.rd_pulse(det_read),
		.reinit(state_q == ST_SWRST),
		.value(max_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// read answer; reads during reset are answered but have no side effect

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= mgmt_req.valid && !mgmt_req.write;
			rsp_q.rdata <= '0;
			if (addr_hit(mgmt_req, 1'b0, phy_mgmt_pkg::REG_CONTROL)) begin
				rsp_q.rdata <= ctl_q & phy_mgmt_pkg::CTL_LIVE_MASK;
			end else if (addr_hit(mgmt_req, 1'b0, phy_mgmt_pkg::REG_DETAIL)) begin
				rsp_q.rdata[phy_mgmt_pkg::DET_RATE] <= rate_100_q;
				rsp_q.rdata[phy_mgmt_pkg::DET_MAX_HI:phy_mgmt_pkg::DET_MAX_LO] <= max_q;
				rsp_q.rdata[phy_mgmt_pkg::DET_LATCH_HIGH] <= lh_q;
				rsp_q.rdata[phy_mgmt_pkg::DET_LATCH_LOW] <= ll_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// rate selection and datapath steering

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rate_100_q <= 1'b1;
		end else if (!cfg_s2_q) begin
			rate_100_q <= rsel_s2_q;
		end else if (ctl_q[phy_mgmt_pkg::CTL_AN_EN]) begin
			rate_100_q <= neg_rate_100;
		end else begin
			rate_100_q <= ctl_q[phy_mgmt_pkg::CTL_RATE];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tp_tx_q <= 1'b0;
			tp_rx_q <= 1'b0;
			coll_en_q <= 1'b0;
		end else begin
			tp_tx_q <= !ctl_q[phy_mgmt_pkg::CTL_LOOPBACK] && !ctl_q[phy_mgmt_pkg::CTL_LOW_POWER]
				&& (state_q == ST_RUN);
			tp_rx_q <= !ctl_q[phy_mgmt_pkg::CTL_LOOPBACK] && !ctl_q[phy_mgmt_pkg::CTL_LOW_POWER]
				&& (state_q == ST_RUN);
			coll_en_q <= !ctl_q[phy_mgmt_pkg::CTL_LOOPBACK]
				|| ctl_q[phy_mgmt_pkg::CTL_COLL_TEST];
		end
	end

	// one register stage keeps the loop delay far below the 512 bit time limit
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mac_rx_q <= '0;
			line_tx_q <= '0;
		end else if (ctl_q[phy_mgmt_pkg::CTL_LOW_POWER] || (state_q != ST_RUN)) begin
			mac_rx_q <= '0;
			line_tx_q <= '0;
		end else if (ctl_q[phy_mgmt_pkg::CTL_LOOPBACK]) begin
			mac_rx_q <= mac_tx;
			line_tx_q <= '0;
		end else begin
			mac_rx_q <= line_rx;
			line_tx_q <= mac_tx;
		end
	end

	assign mgmt_rsp = rsp_q;
	assign mac_rx = mac_rx_q;
	assign line_tx = line_tx_q;
	assign tp_tx_enable = tp_tx_q;
	assign tp_rx_enable = tp_rx_q;
	assign coll_detect_enable = coll_en_q;
	assign rate_100 = rate_100_q;
	assign an_enable = ctl_q[phy_mgmt_pkg::CTL_AN_EN];
	assign an_restart = ctl_q[phy_mgmt_pkg::CTL_AN_RESTART];
	assign low_power = ctl_q[phy_mgmt_pkg::CTL_LOW_POWER];
	assign isolate = ctl_q[phy_mgmt_pkg::CTL_ISOLATE];
	assign duplex_full = ctl_q[phy_mgmt_pkg::CTL_DUPLEX];
	assign state_reset = ctl_q[phy_mgmt_pkg::CTL_RESET];
	assign mgmt_busy = ctl_q[phy_mgmt_pkg::CTL_RESET];

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	lh_hold_a: assert property (lh_q && !det_read && !latch_reinit |=> lh_q)
		else $error("event high bit dropped without a read");
	lh_reload_a: assert property (det_read && !latch_reinit |=> lh_q == $past(link_event))
		else $error("event high bit not reloaded after read");
	ll_hold_a: assert property (!ll_q && !det_read && !latch_reinit |=> !ll_q)
		else $error("event low bit rose without a read");
	ll_second_read_a: assert property (det_read ##1 det_read |-> ##1
		mgmt_rsp.rdata[phy_mgmt_pkg::DET_LATCH_LOW] == $past(link_fault_n, 2))
		else $error("second read of event low bit not live");
	max_monotone_a: assert property (!det_read && state_q != ST_SWRST
		|=> max_q >= $past(max_q))
		else $error("maximum group decreased without a read");
	max_reload_a: assert property (det_read |=> max_q == $past(mon_state))
		else $error("maximum group not reloaded after read");
	restart_clear_a: assert property (an_restart_done && !ctl_write && state_q == ST_RUN
		|=> !an_restart)
		else $error("restart trigger not cleared on completion");
	restart_gate_a: assert property (!an_enable |-> !an_restart)
		else $error("restart armed with negotiation off");
	swrst_span_a: assert property (sw_start |=> mgmt_busy [*8])
		else $error("software reset bit fell too early");
	swrst_ignore_a: assert property (state_q == ST_SWRST && cnt_q != SWRST_LAST
		&& mgmt_req.valid && mgmt_req.write |=> mgmt_busy && !low_power)
		else $error("write landed during software reset");
	loop_dv_a: assert property (state_q == ST_RUN && low_power == 1'b0 && mac_tx.en
		&& ctl_q[phy_mgmt_pkg::CTL_LOOPBACK] |=> mac_rx.en && !line_tx.en)
		else $error("loopback receive valid late");
	coll_loop_a: assert property (ctl_q[phy_mgmt_pkg::CTL_LOOPBACK]
		|=> coll_detect_enable == $past(ctl_q[phy_mgmt_pkg::CTL_COLL_TEST]))
		else $error("collision enable wrong in loopback");
	rate_hw_a: assert property (!cfg_s2_q |=> rate_100 == $past(rsel_s2_q))
		else $error("hardware rate not taken from pin");
	rate_sw_a: assert property (cfg_s2_q && !an_enable
		|=> rate_100 == $past(ctl_q[phy_mgmt_pkg::CTL_RATE]))
		else $error("software rate bit not obeyed");
	defaults_a: assert property ($fell(mgmt_busy) && state_q == ST_RUN |-> an_enable
		&& ctl_q[phy_mgmt_pkg::CTL_RATE] && !low_power
		&& isolate == (strap_q == phy_mgmt_pkg::STRAP_ISOLATE_ADDR))
		else $error("control defaults wrong after software reset");
	rsvd_zero_a: assert property (addr_hit(mgmt_req, 1'b0, phy_mgmt_pkg::REG_CONTROL)
		|=> mgmt_rsp.valid && mgmt_rsp.rdata[6:0] == 7'h00)
		else $error("reserved control bits not zero");
	lp_latch_a: assert property (lp_enter |=> lh_q == $past(link_event)
		&& ll_q == $past(link_fault_n) && low_power)
		else $error("low power entry did not reinit event bits");

	swrst_c: cover property (sw_start ##[1:40] $fell(mgmt_busy));
	double_read_c: cover property (det_read ##1 det_read);
	loop_c: cover property (ctl_q[phy_mgmt_pkg::CTL_LOOPBACK] && mac_tx.en ##1 mac_rx.en);
	lp_c: cover property (lp_enter);
endmodule
`default_nettype wire

// *** include/phy_mgmt_pkg.sv ***
package phy_mgmt_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 5;
	localparam int MAX_W = 3;
	localparam int STRAP_W = 5;

	localparam logic [ADDR_W-1:0] REG_CONTROL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_DETAIL = 5'h11;

	localparam int CTL_RESET = 15;
	localparam int CTL_LOOPBACK = 14;
	localparam int CTL_RATE = 13;
	localparam int CTL_AN_EN = 12;
	localparam int CTL_LOW_POWER = 11;
	localparam int CTL_ISOLATE = 10;
	localparam int CTL_AN_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_COLL_TEST = 7;
	localparam logic [DATA_W-1:0] CTL_DEFAULT = 16'h3000;
	localparam logic [DATA_W-1:0] CTL_LIVE_MASK = 16'hFF80;

	localparam int DET_RATE = 15;
	localparam int DET_MAX_HI = 13;
	localparam int DET_MAX_LO = 11;
	localparam int DET_LATCH_HIGH = 1;
	localparam int DET_LATCH_LOW = 0;

	localparam logic LATCH_HIGH_DEFAULT = 1'b0;
	localparam logic LATCH_LOW_DEFAULT = 1'b1;
	localparam logic [MAX_W-1:0] MAX_DEFAULT = 3'h0;
	localparam logic [STRAP_W-1:0] STRAP_ISOLATE_ADDR = 5'h00;

	localparam int CLK_PERIOD_NS = 40;
	localparam int BOOT_CYCLES = 3;
	localparam int SW_RESET_CYCLES = 16;
	localparam int LOOP_MAX_BIT_TIMES = 512;
	localparam int BIT_TIME_NS = 10;
	localparam int LOOP_MAX_CYCLES = LOOP_MAX_BIT_TIMES * BIT_TIME_NS / CLK_PERIOD_NS;

	typedef enum {LATCH_HIGH, LATCH_LOW, LATCH_MAX} latch_kind_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mgmt_req_s;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] rdata;
	} mgmt_rsp_s;

	typedef struct packed {
		logic en;
		logic [3:0] data;
	} mii_beat_s;
endpackage

// *** verification/mgmt_entity_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module mgmt_entity_model (
	input wire logic ref_clk,
	output var phy_mgmt_pkg::mgmt_req_s mgmt_req
);
	initial mgmt_req = '0;

	////////////////////////////////////////////////////////////////////////////////
	// caller sits just past a rising edge; the request is taken at the next one
	task automatic xfer(input logic v, input logic w, input logic [4:0] a, input logic [15:0] d);
		mgmt_req <= '{v, w, a, (w && a == phy_mgmt_pkg::REG_CONTROL) ? d & 16'hFF80 : d};
		@(posedge ref_clk);
	endtask

	// a released bus never shows the last value, so idle cycles flip it
	task automatic idle(input int n);
		repeat (n) begin
			mgmt_req <= {1'b0, ~mgmt_req[21:0]};
			@(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

// *** verification/phy_mgmt_control_register_bits_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_control_register_bits_tb;
	localparam int SWR = 8;
	logic ref_clk, nrst, config_source_pin, rate_select_pin, link_event, link_fault_n;
	logic neg_rate_100, an_restart_done, tp_tx_enable, tp_rx_enable, coll_detect_enable;
	logic rate_100, an_enable, an_restart, low_power, isolate, duplex_full, state_reset, mgmt_busy;
	logic [4:0] phy_addr_strap;
	logic [2:0] mon_state, v, mx;
	logic [15:0] d, ctl;
	logic [4:0] tx[6], rx[6];
	phy_mgmt_pkg::mgmt_req_s mgmt_req;
	phy_mgmt_pkg::mgmt_rsp_s mgmt_rsp;
	phy_mgmt_pkg::mii_beat_s mac_tx, line_rx, mac_rx, line_tx;
	int errors = 0, total_checks = 0, cyc = 0, n;
	logic [15:0] exp_q[$];

	phy_mgmt_ctrl #(.SW_RESET_CYCLES(SWR)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
		.config_source_pin(config_source_pin), .rate_select_pin(rate_select_pin),
		.phy_addr_strap(phy_addr_strap), .link_event(link_event),
		.link_fault_n(link_fault_n), .mon_state(mon_state), .neg_rate_100(neg_rate_100),
		.an_restart_done(an_restart_done), .mac_tx(mac_tx), .line_rx(line_rx),
		.mac_rx(mac_rx), .line_tx(line_tx), .tp_tx_enable(tp_tx_enable),
		.tp_rx_enable(tp_rx_enable), .coll_detect_enable(coll_detect_enable),
		.rate_100(rate_100), .an_enable(an_enable), .an_restart(an_restart),
		.low_power(low_power), .isolate(isolate), .duplex_full(duplex_full),
		.state_reset(state_reset), .mgmt_busy(mgmt_busy)
	);
	mgmt_entity_model sta (
		.ref_clk(ref_clk),
		.mgmt_req(mgmt_req)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	function automatic logic rate_of(input logic [15:0] c);
		return config_source_pin ? (c[12] ? neg_rate_100 : c[13]) : rate_select_pin;
	endfunction

	function automatic logic [15:0] det(input logic r, input logic [2:0] m, input logic h,
		input logic l);
		det = 16'h0000;
		det[phy_mgmt_pkg::DET_RATE] = r;
		det[phy_mgmt_pkg::DET_MAX_HI:phy_mgmt_pkg::DET_MAX_LO] = m;
		det[phy_mgmt_pkg::DET_LATCH_HIGH] = h;
		det[phy_mgmt_pkg::DET_LATCH_LOW] = l;
	endfunction

	task automatic wr(input logic [15:0] w);
		sta.xfer(1'b1, 1'b1, phy_mgmt_pkg::REG_CONTROL, w);
		sta.idle(1);
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		sta.xfer(1'b1, 1'b0, a, 16'h0000);
	endtask

	task automatic hard_reset(input logic [4:0] s);
		nrst <= 1'b0;
		phy_addr_strap <= s;
		sta.idle(20);
		nrst <= 1'b1;
		sta.idle(6);
		ctl = phy_mgmt_pkg::CTL_DEFAULT | ((s == 5'h00) ? 16'h0400 : 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// read answers are matched against the oldest note
	always @(posedge ref_clk) begin
		if (mgmt_rsp.valid === 1'b1) begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000);
			else
				check(mgmt_rsp.rdata, exp_q.pop_front());
		end
	end

	// the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		{config_source_pin, rate_select_pin, neg_rate_100, an_restart_done} = 4'h8;
		{link_event, link_fault_n, mon_state} = 5'h08;
		phy_addr_strap = 5'h00;
		mac_tx = '0;
		line_rx = '0;
		void'($urandom(66194));
		for (int i = 0; i < 2; i++) begin
			hard_reset(i ? 5'h0a : 5'h00);
			rd(phy_mgmt_pkg::REG_CONTROL, ctl);
			rd(phy_mgmt_pkg::REG_DETAIL, det(rate_of(ctl), 3'h0, 1'b0, 1'b1));
			sta.idle(2);
			check(isolate, ctl[10]);
			check({an_enable, low_power, duplex_full, an_restart, mgmt_busy}, 5'h10);
		end
		for (int i = 0; i < 6; i++) begin
			{config_source_pin, rate_select_pin, neg_rate_100} <= 3'($urandom());
			sta.idle(4);
			d = 16'($urandom()) & 16'h7D80;
			wr(d);
			ctl = d;
			check({an_enable, low_power, isolate, duplex_full}, {d[12], d[11:10], d[8]});
			sta.idle(1);
			check(tp_tx_enable, !d[14] && !d[11]);
			check(coll_detect_enable, !d[14] || d[7]);
			check(rate_100, rate_of(d));
			rd(phy_mgmt_pkg::REG_CONTROL, d);
			rd(phy_mgmt_pkg::REG_DETAIL, det(rate_of(d), 3'h0, 1'b0, 1'b1));
			sta.idle(2);
		end
		wr(16'h1000);
		ctl = 16'h1000;
		{link_event, link_fault_n} <= 2'b10;
		sta.idle(1);
		mx = 3'h0;
		for (int i = 0; i < 6; i++) begin
			v = 3'($urandom());
			{link_event, link_fault_n, mon_state} <= {2'b01, v};
			if (v > mx)
				mx = v;
			sta.idle(1);
		end
		sta.idle(2);
		rd(phy_mgmt_pkg::REG_DETAIL, det(rate_of(ctl), mx, 1'b1, 1'b0));
		rd(phy_mgmt_pkg::REG_DETAIL, det(rate_of(ctl), v, 1'b0, 1'b1));
		{link_event, link_fault_n} <= 2'b10;
		sta.idle(1);
		{link_event, link_fault_n} <= 2'b01;
		wr(16'h1800);
		ctl = 16'h1800;
		rd(phy_mgmt_pkg::REG_DETAIL, det(rate_of(ctl), v, 1'b0, 1'b1));
		sta.idle(2);
		for (int lb = 0; lb < 2; lb++) begin
			wr(lb ? 16'h5000 : 16'h1000);
			sta.idle(1);
			check(tp_rx_enable, !lb);
			for (int i = 0; i < 6; i++) begin
				if (i > 1) begin
					check(mac_rx, lb ? tx[i-2] : rx[i-2]);
					check(line_tx, lb ? 5'h00 : tx[i-2]);
				end
				tx[i] = 5'($urandom());
				rx[i] = 5'($urandom());
				mac_tx <= tx[i];
				line_rx <= rx[i];
				sta.idle(1);
			end
		end
		wr(16'h0200);
		check(an_restart, 1'b0);
		wr(16'h1200);
		check(an_restart, 1'b1);
		sta.idle(3);
		check(an_restart, 1'b1);
		an_restart_done <= 1'b1;
		sta.idle(1);
		an_restart_done <= 1'b0;
		sta.idle(1);
		check(an_restart, 1'b0);
		wr(16'h4100);
		// second write lands while the reset runs and must be dropped
		sta.xfer(1'b1, 1'b1, phy_mgmt_pkg::REG_CONTROL, 16'h8000);
		sta.xfer(1'b1, 1'b1, phy_mgmt_pkg::REG_CONTROL, 16'h4000);
		rd(phy_mgmt_pkg::REG_CONTROL, 16'hB000);
		check({state_reset, mgmt_busy}, 2'b11);
		n = 0;
		while (mgmt_busy === 1'b1 && n < 40) begin
			sta.idle(1);
			n++;
		end
		check(n >= SWR - 2 && n <= SWR, 1'b1);
		rd(phy_mgmt_pkg::REG_CONTROL, 16'h3000);
		sta.idle(3);
		check(16'(exp_q.size()), 16'h0000);
		results();
	end
endmodule
`default_nettype wire
